// ---- src/pw_compare.sv ----
// word-serial 32-byte password comparator
// assumes: words arrive in order, index 0..PW_WORDS-1, with clear before each sector
`timescale 1ns/10ps
module pw_compare #(
	parameter int WORDS = 16
) (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	// word stream
	input  wire logic        clear_i,
	input  wire logic        word_en_i,
	input  wire logic [3:0]  word_idx_i,
	input  wire logic [15:0] rx_word_i,
	input  wire logic [15:0] ref_word_i,
	// result
	output logic             mismatch_o
);
	// sticky mismatch over the 16 password words
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || clear_i) begin
			mismatch_o <= 1'b0;
		end else if (word_en_i && (32'(word_idx_i) < WORDS) && (rx_word_i != ref_word_i)) begin
			mismatch_o <= 1'b1;
		end
	end
endmodule

// ---- src/sec_erase_ctrl.sv ----
// security erase-prepare / erase-unit / freeze-lock command interpreter
// assumes: command strobe decoded from command-block, sector data word-serial,
// media writer accepts one zero word per ack; power_on_i high only at power-up
`timescale 1ns/10ps
module sec_erase_ctrl
	import sec_erase_pkg::*;
#(
	parameter logic [47:0] NATIVE_TOP = 48'h0000_0000_03FF
) (
	// clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      srst_i,
	input  wire logic                      power_on_i,
	// command block
	input  wire logic                      cmd_wr_i,
	input  wire logic [7:0]                cmd_opcode_i,
	input  wire logic [47:0]               host_visible_top_sector_i,
	// sector data from host
	input  wire sec_erase_pkg::pdata_t     pdata_i,
	// stored passwords and lock state
	input  wire logic [15:0]               user_pw_word_i,
	input  wire logic [15:0]               master_pw_word_i,
	input  wire logic                      lock_enabled_i,
	// media writer
	input  wire logic                      media_ack_i,
	// outputs
	output logic [7:0]                     command_error_flags_o,
	output logic [7:0]                     device_condition_flags_o,
	output logic [3:0]                     pw_word_idx_o,
	output sec_erase_pkg::media_wr_t       media_wr_o,
	output logic                           lock_disable_o,
	output logic                           frozen_o,
	output logic [15:0]                    id_erase_time_o
);
	import sec_erase_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_DATA = 3'b001,
		S_CHK  = 3'b011,
		S_ERASE = 3'b010,
		S_DONE = 3'b110
	} state_t;

	state_t      state;
	logic        armed;
	logic        use_master;
	logic [8:0]  word_cnt;
	logic [47:0] lba;
	logic        mismatch;
	logic        is_lock_cmd;
	logic        abort_now;

	////////////////////////////////////////////////////////////////////////
	// command classification
	assign is_lock_cmd = (cmd_opcode_i == OPC_SET_PW) || (cmd_opcode_i == OPC_UNLOCK) ||
		(cmd_opcode_i == OPC_DIS_PW) || (cmd_opcode_i == OPC_ERASE_UNIT);
	// immediate aborts: frozen lock commands, or unarmed erase
	assign abort_now = cmd_wr_i && (state == S_IDLE) &&
		((frozen_o && is_lock_cmd) ||
		 (cmd_opcode_i == OPC_ERASE_UNIT && !armed));

	////////////////////////////////////////////////////////////////////////
	// frozen latch, cleared only by power-on, never by srst_i
	always_ff @(posedge clk_sys_i) begin
		if (power_on_i) begin
			frozen_o <= 1'b0;
		end else if (cmd_wr_i && state == S_IDLE && cmd_opcode_i == OPC_FREEZE) begin
			frozen_o <= 1'b1;
		end
	end

	// erase arm: set by completed prepare, dropped by any other command
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			armed <= 1'b0;
		end else if (cmd_wr_i && state == S_IDLE) begin
			armed <= (cmd_opcode_i == OPC_ERASE_PREP);
		end
	end

	// identification word 89
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			id_erase_time_o <= ERASE_TIME_MIN;
		end else begin
			id_erase_time_o <= ERASE_TIME_MIN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// password comparator
	pw_compare #(
		.WORDS(PW_WORDS)
	) u_cmp (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.clear_i   (state == S_IDLE),
		.word_en_i (pdata_i.valid && state == S_DATA && word_cnt >= 9'd1 &&
			word_cnt <= 9'(PW_WORDS)),
		.word_idx_i(pw_word_idx_o),
		.rx_word_i (pdata_i.data),
		.ref_word_i(use_master ? master_pw_word_i : user_pw_word_i),
		.mismatch_o(mismatch)
	);

	////////////////////////////////////////////////////////////////////////
	// erase sequencer
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state          <= S_IDLE;
			word_cnt       <= 9'd0;
			use_master     <= 1'b0;
			lba            <= 48'd0;
			pw_word_idx_o  <= 4'd0;
			media_wr_o     <= '0;
			lock_disable_o <= 1'b0;
		end else begin
			lock_disable_o <= 1'b0;
			case (state)
				S_IDLE: begin
					word_cnt <= 9'd0;
					pw_word_idx_o <= 4'd0;
					if (cmd_wr_i && !abort_now && cmd_opcode_i == OPC_ERASE_UNIT) begin
						state <= S_DATA;
					end
				end
				S_DATA: begin
					if (pdata_i.valid) begin
						if (word_cnt == 9'd0) begin
							use_master <= pdata_i.data[CW_MASTER_BIT];
						end
						if (word_cnt >= 9'd1 && word_cnt < 9'(PW_WORDS)) begin
							pw_word_idx_o <= 4'(word_cnt);
						end
						word_cnt <= word_cnt + 9'd1;
						if (word_cnt == 9'(SECTOR_WORDS - 1)) begin
							state <= S_CHK;
						end
					end
				end
				S_CHK: begin
					// bit 1 enhanced mode ignored: normal erase only, bits 2-15 reserved
					lba <= 48'd0;
					if (mismatch && lock_enabled_i) begin
						state <= S_DONE;
					end else begin
						state <= S_ERASE;
					end
				end
				S_ERASE: begin
					// zero writes only, no verify reads, no defect-list access
					media_wr_o.req  <= 1'b1;
					media_wr_o.lba  <= lba;
					media_wr_o.data <= ZERO_WORD;
					if (media_wr_o.req && media_ack_i) begin
						// native top bounds the walk, host-visible top unused
						if (lba == NATIVE_TOP) begin
							media_wr_o.req <= 1'b0;
							lock_disable_o <= 1'b1;
							state <= S_DONE;
						end else begin
							lba <= lba + 48'd1;
							media_wr_o.lba <= lba + 48'd1;
						end
					end
				end
				S_DONE: begin
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error and status registers
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			command_error_flags_o    <= ERR_RESET;
			device_condition_flags_o <= STATUS_RESET;
		end else begin
			device_condition_flags_o[ST_BSY_BIT] <= (state == S_CHK) || (state == S_ERASE);
			device_condition_flags_o[ST_DRQ_BIT] <= (state == S_DATA);
			if (abort_now || (state == S_CHK && mismatch && lock_enabled_i)) begin
				command_error_flags_o[ERR_ABT_BIT]  <= 1'b1;
				device_condition_flags_o[ST_ERR_BIT] <= 1'b1;
			end else if (cmd_wr_i && state == S_IDLE) begin
				command_error_flags_o <= ERR_RESET;
				device_condition_flags_o[ST_ERR_BIT] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_unarmed_erase: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cmd_wr_i && state == S_IDLE && cmd_opcode_i == OPC_ERASE_UNIT && !armed && !frozen_o
		|=> command_error_flags_o[ERR_ABT_BIT] && state == S_IDLE)
		else $error("unarmed erase not aborted");
	a_frozen_reject: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cmd_wr_i && state == S_IDLE && frozen_o && is_lock_cmd
		|=> device_condition_flags_o[ST_ERR_BIT] && state != S_DATA)
		else $error("frozen lock command accepted");
	a_freeze_sticky: assert property (@(posedge clk_sys_i)
		!power_on_i && frozen_o |=> frozen_o)
		else $error("frozen state lost");
	a_freeze_enter: assert property (@(posedge clk_sys_i) disable iff (power_on_i)
		cmd_wr_i && state == S_IDLE && cmd_opcode_i == OPC_FREEZE |=> frozen_o)
		else $error("freeze not entered");
	a_pw_abort: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		state == S_CHK && mismatch && lock_enabled_i
		|=> state == S_DONE && command_error_flags_o[ERR_ABT_BIT])
		else $error("mismatch not aborted");
	a_unlocked_erase: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		state == S_CHK && !lock_enabled_i |=> state == S_ERASE)
		else $error("unlocked erase skipped");
	a_zero_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		media_wr_o.req |-> media_wr_o.data == ZERO_WORD && media_wr_o.lba <= NATIVE_TOP)
		else $error("nonzero or out of range write");
	a_erase_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(media_wr_o.req) |-> media_wr_o.lba == 48'd0)
		else $error("erase did not start at sector 0");
	a_data_phase: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cmd_wr_i && state == S_IDLE && !abort_now && cmd_opcode_i == OPC_ERASE_UNIT
		|=> ##1 device_condition_flags_o[ST_DRQ_BIT])
		else $error("no data request");
	a_prep_nodata: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		cmd_wr_i && state == S_IDLE && cmd_opcode_i == OPC_ERASE_PREP |=> state == S_IDLE && armed)
		else $error("prepare entered data phase");
	c_freeze: cover property (@(posedge clk_sys_i) $rose(frozen_o));
	c_erase_done: cover property (@(posedge clk_sys_i) lock_disable_o);
	c_pw_fail: cover property (@(posedge clk_sys_i) state == S_CHK && mismatch && lock_enabled_i);
endmodule

// ---- src/sec_erase_pkg.sv ----
// constants and types for the security erase / freeze command interpreter
// assumes: command-block registers reach the block as a decoded command strobe
// Operation
// - opcode F3h arms a following erase-unit command
// - erase-prepare completes with no data phase
// - opcode F4h erases all user sectors then disables lock
// - erase-unit requests exactly one parameter sector before erasing
// - erase-unit aborts unless directly preceded by completed erase-prepare
// - word 0 bit 0 selects master (1) or user (0) password
// - word 0 bit 1 erase mode; only normal supported; bits 2-15 reserved
// - 32-byte password in words 1-16 compared; mismatch aborts
// - erase spans sector 0 to native top, ignoring host-visible top
// - erase writes zeros only, no read-back verify
// - defect and reassignment records are left unchanged
// - erase disables lock but keeps the master password
// - lock already disabled: skip password compare, erase anyway
// - erase time reported in identification word 89
// - opcode F5h enters frozen state at once
// - frozen state clears only on power removal
// - frozen rejects set-password, unlock, disable-password, erase-unit
package sec_erase_pkg;
	localparam logic [7:0] OPC_ERASE_PREP = 8'hF3;
	localparam logic [7:0] OPC_ERASE_UNIT = 8'hF4;
	localparam logic [7:0] OPC_FREEZE     = 8'hF5;
	localparam logic [7:0] OPC_SET_PW     = 8'hF1;
	localparam logic [7:0] OPC_UNLOCK     = 8'hF2;
	localparam logic [7:0] OPC_DIS_PW     = 8'hF6;
	localparam int         ERR_ABT_BIT    = 2;
	localparam int         ST_ERR_BIT     = 0;
	localparam int         ST_DRQ_BIT     = 3;
	localparam int         ST_DSC_BIT     = 4;
	localparam int         ST_RDY_BIT     = 6;
	localparam int         ST_BSY_BIT     = 7;
	localparam int         CW_MASTER_BIT  = 0;
	localparam int         CW_MODE_BIT    = 1;
	localparam int         PW_WORDS       = 16;
	localparam int         SECTOR_WORDS   = 256;
	localparam int         ID_ERASE_TIME_WORD = 89;
	localparam logic [7:0] ERR_RESET      = 8'h00;
	localparam logic [7:0] STATUS_RESET   = 8'h50;
	localparam logic [15:0] ERASE_TIME_MIN = 16'h0064;
	localparam logic [15:0] ZERO_WORD     = 16'h0000;
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} pdata_t;
	typedef struct packed {
		logic        req;
		logic [47:0] lba;
		logic [15:0] data;
	} media_wr_t;
endpackage

// ---- tb/drive_security_erase_freeze_tb.sv ----
// bench for the security erase / freeze command interpreter
// assumes: top sector shortened to 7, stored passwords derived from the index
`timescale 1ns/10ps
module drive_security_erase_freeze_tb;
	import sec_erase_pkg::*;
	logic        clk_sys_i, srst_i, power_on_i, cmd_wr_i, lock_enabled_i, media_ack_i;
	logic        lock_disable_o, frozen_o;
	logic [7:0]  cmd_opcode_i, command_error_flags_o, device_condition_flags_o;
	logic [3:0]  pw_word_idx_o;
	logic [15:0] user_pw_word_i, master_pw_word_i, id_erase_time_o;
	logic [47:0] host_visible_top_sector_i;
	pdata_t      pdata_i;
	media_wr_t   media_wr_o;
	int          fails, checked, writes, unlocks, cycles;
	sec_erase_ctrl #(
		.NATIVE_TOP(48'h0000_0000_0007)
	) sec_erase_ctrl_i (
		.clk_sys_i                (clk_sys_i),
		.srst_i                   (srst_i),
		.power_on_i               (power_on_i),
		.cmd_wr_i                 (cmd_wr_i),
		.cmd_opcode_i             (cmd_opcode_i),
		.host_visible_top_sector_i(host_visible_top_sector_i),
		.pdata_i                  (pdata_i),
		.user_pw_word_i           (user_pw_word_i),
		.master_pw_word_i         (master_pw_word_i),
		.lock_enabled_i           (lock_enabled_i),
		.media_ack_i              (media_ack_i),
		.command_error_flags_o    (command_error_flags_o),
		.device_condition_flags_o (device_condition_flags_o),
		.pw_word_idx_o            (pw_word_idx_o),
		.media_wr_o               (media_wr_o),
		.lock_disable_o           (lock_disable_o),
		.frozen_o                 (frozen_o),
		.id_erase_time_o          (id_erase_time_o)
	);
	host_adapter_model host_adapter_model_i (.clk_sys_i(clk_sys_i),
		.status_i(device_condition_flags_o), .cmd_wr_o(cmd_wr_i),
		.cmd_opcode_o(cmd_opcode_i), .pdata_o(pdata_i));
	// stored passwords answer the index at once
	assign user_pw_word_i = 16'h1000 + 16'(pw_word_idx_o);
	assign master_pw_word_i = 16'h2000 + 16'(pw_word_idx_o);
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// writer stalls every other cycle
	always @(posedge clk_sys_i) media_ack_i <= #1 ~media_ack_i;
	// media monitor and timeout
	always @(posedge clk_sys_i) begin
		if (media_wr_o.req === 1'b1 && media_ack_i === 1'b1) begin
			check(media_wr_o.data, 64'(ZERO_WORD));
			check(media_wr_o.lba, 64'(writes));
			writes++;
		end
		if (lock_disable_o === 1'b1) unlocks++;
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	task automatic erase(input logic [15:0] ctl, input logic [15:0] pw, input logic ok);
		int n;
		n = 0;
		writes = 0;
		unlocks = 0;
		host_adapter_model_i.send_cmd(OPC_ERASE_PREP);
		repeat (3) @(posedge clk_sys_i);
		#1;
		check(device_condition_flags_o[ST_DRQ_BIT], 1'b0);
		check(command_error_flags_o[ERR_ABT_BIT], 1'b0);
		host_adapter_model_i.send_cmd(OPC_ERASE_UNIT);
		host_adapter_model_i.send_sector(ctl, pw);
		repeat (3) @(posedge clk_sys_i);
		#1;
		while ((device_condition_flags_o[ST_BSY_BIT] | device_condition_flags_o[ST_DRQ_BIT])
			!== 1'b0 && n < 200) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check(command_error_flags_o[ERR_ABT_BIT], !ok);
		check(device_condition_flags_o[ST_ERR_BIT], !ok);
		check(writes, ok ? 8 : 0);
		check(unlocks, ok ? 1 : 0);
	endtask
	task automatic t_reset();
		check(command_error_flags_o, ERR_RESET);
		check(device_condition_flags_o, STATUS_RESET);
		check(id_erase_time_o, ERASE_TIME_MIN);
		check(frozen_o, 1'b0);
	endtask
	task automatic t_unarmed();
		host_adapter_model_i.send_cmd(OPC_ERASE_UNIT);
		@(posedge clk_sys_i);
		#1;
		check(command_error_flags_o[ERR_ABT_BIT], 1'b1);
		check(device_condition_flags_o[ST_ERR_BIT], 1'b1);
		check(device_condition_flags_o[ST_DRQ_BIT], 1'b0);
		// prepare, then another command in between: arm is lost
		host_adapter_model_i.send_cmd(OPC_ERASE_PREP);
		host_adapter_model_i.send_cmd(OPC_SET_PW);
		host_adapter_model_i.send_cmd(OPC_ERASE_UNIT);
		@(posedge clk_sys_i);
		#1;
		check(command_error_flags_o[ERR_ABT_BIT], 1'b1);
		check(device_condition_flags_o[ST_DRQ_BIT], 1'b0);
	endtask
	task automatic t_passwords();
		erase(16'h0000, 16'h1000, 1'b1);
		erase(16'h0001, 16'h2000, 1'b1);
		erase(16'h0001, 16'h1000, 1'b0);
		erase(16'h0002, 16'h1000, 1'b1);
		lock_enabled_i = 1'b0;
		erase(16'h0000, 16'h3000, 1'b1);
		lock_enabled_i = 1'b1;
	endtask
	task automatic t_frozen();
		logic [7:0] ops [3];
		ops = '{OPC_SET_PW, OPC_UNLOCK, OPC_DIS_PW};
		host_adapter_model_i.send_cmd(OPC_FREEZE);
		@(posedge clk_sys_i);
		#1;
		check(frozen_o, 1'b1);
		foreach (ops[i]) begin
			host_adapter_model_i.send_cmd(ops[i]);
			@(posedge clk_sys_i);
			#1;
			check(command_error_flags_o[ERR_ABT_BIT], 1'b1);
		end
		erase(16'h0000, 16'h1000, 1'b0);
		srst_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		srst_i = 1'b0;
		check(frozen_o, 1'b1);
		power_on_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		power_on_i = 1'b0;
		check(frozen_o, 1'b0);
	endtask
	// reset, then the scenarios in turn
	initial begin
		{fails, checked, writes, unlocks, cycles} = '0;
		{srst_i, power_on_i, lock_enabled_i} = 3'b111;
		media_ack_i = 1'b0;
		host_visible_top_sector_i = 48'h0000_0000_0003;
		repeat (5) @(posedge clk_sys_i);
		#1;
		{srst_i, power_on_i} = 2'b00;
		t_reset();
		t_unarmed();
		t_passwords();
		t_frozen();
		summarize();
	end
endmodule

// ---- tb/host_adapter_model.sv ----
// host adapter model: writes commands and sends the parameter sector
// assumes: drive status bits as in the package, one word per clock during drq
`timescale 1ns/10ps
module host_adapter_model (
	// clock and drive status
	input  wire logic             clk_sys_i,
	input  wire logic [7:0]       status_i,
	// command block and data
	output logic                  cmd_wr_o,
	output logic [7:0]            cmd_opcode_o,
	output sec_erase_pkg::pdata_t pdata_o
);
	import sec_erase_pkg::*;
	// idle bus at time zero
	initial begin
		cmd_wr_o = 1'b0;
		cmd_opcode_o = 8'h00;
		pdata_o = '0;
	end
	// one command strobe, issued once the drive is idle or after 2000 cycles of polling
	task automatic send_cmd(input logic [7:0] op);
		int n;
		n = 0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		while ((status_i[ST_BSY_BIT] | status_i[ST_DRQ_BIT]) !== 1'b0 && n < 2000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		cmd_wr_o = 1'b1;
		cmd_opcode_o = op;
		@(posedge clk_sys_i);
		#1;
		cmd_wr_o = 1'b0;
	endtask
	// whole sector: control word, password words, filler
	task automatic send_sector(input logic [15:0] ctl, input logic [15:0] pw);
		int n;
		n = 0;
		while (status_i[ST_DRQ_BIT] !== 1'b1 && n < 50) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		// no words at all unless the drive asked for them
		for (int w = 0; w < SECTOR_WORDS && status_i[ST_DRQ_BIT] === 1'b1; w++) begin
			pdata_o.valid = 1'b1;
			pdata_o.data = (w == 0) ? ctl : (w <= PW_WORDS) ? pw + 16'(w - 1) : 16'(w);
			@(posedge clk_sys_i);
			#1;
		end
		pdata_o.valid = 1'b0;
	endtask
endmodule
